// ### adc_pkg.sv
/*
 * Constants shared by the converter result, channel and pin register block.
 * Assumes a 16-bit CPU address space and 8/16-bit data accesses.
 */
`default_nettype none

package adc_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [15:0] OFF_RESULT_LO   = 16'hff08;
    localparam logic [15:0] OFF_RESULT_HI   = 16'hff09;
    localparam logic [15:0] OFF_RESULT_BYTE = 16'hff1f;
    localparam logic [15:0] OFF_CHAN_SEL    = 16'hff29;
    localparam logic [15:0] OFF_PIN_CFG     = 16'hff2f;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int          RES_BITS     = 10;
    localparam int          RES_PAD      = 6;
    localparam int          CHAN_BITS    = 3;
    localparam int          PIN_BITS     = 4;
    localparam int          PIN_CNT      = 8;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [7:0]  BYTE_RESET   = 8'h00;
    localparam logic [2:0]  CHAN_RESET   = 3'h0;
    localparam logic [3:0]  PIN_RESET    = 4'h0;
    localparam logic [15:0] RDATA_RESET  = 16'h0000;

    // ----------------------------------------------------------------
    // Bus handshake states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WAIT,
        BUS_DONE
    } bus_state_t;
endpackage : adc_pkg

`default_nettype wire

// ### adc_result_if.sv
/*
 * Carrier between the register block and its result store.
 * Assumes both ends run on sys_clk.
 */
`default_nettype none

interface adc_result_if;
    logic        load;
    logic [9:0]  successive_approx_reg;
    logic [15:0] word;
    logic [7:0]  byte_hi;

    modport store (
        input  load,
        input  successive_approx_reg,
        output word,
        output byte_hi
    );
    modport regs (
        output load,
        output successive_approx_reg,
        input  word,
        input  byte_hi
    );
endinterface : adc_result_if

`default_nettype wire

// ### adc_result_store.sv
/*
 * Holds the 16-bit left-justified result word and the 8-bit upper result.
 * Assumes load is a one-cycle pulse on sys_clk at conversion end.
 */
`default_nettype none

module adc_result_store (
    // Clock and reset
    input  wire logic    sys_clk,
    input  wire logic    rst,
    // Result carrier
    adc_result_if.store  res
);
    logic [15:0] word_ff;
    logic [7:0]  byte_ff;

    // No CPU write path reaches these, so writes leave them untouched
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            word_ff <= adc_pkg::RESULT_RESET; // RULE4
            byte_ff <= adc_pkg::BYTE_RESET; // RULE5
        end else if (res.load) begin
            word_ff <= {res.successive_approx_reg, {adc_pkg::RES_PAD{1'b0}}}; // RULE1
            byte_ff <= res.successive_approx_reg[adc_pkg::RES_BITS-1 -: 8]; // RULE5
        end
    end // RULE2 RULE19

    assign res.word    = word_ff;
    assign res.byte_hi = byte_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_result_low_zero: assert property (word_ff[5:0] == 6'h00) // RULE1
        else $error("result low bits not zero");
    a_result_load_copy: assert property (res.load |=> word_ff[15:6] == $past(res.successive_approx_reg)) // RULE2
        else $error("result not loaded at conversion end");
    a_result_byte_top: assert property (res.load |=> byte_ff == $past(res.successive_approx_reg[9:2])) // RULE5
        else $error("upper result byte mismatch");
    a_result_hold_idle: assert property (!res.load |=> $stable(word_ff) && $stable(byte_ff)) // RULE19
        else $error("result changed without a conversion end");
endmodule : adc_result_store

`default_nettype wire

// ### adc_result_channel_pin_regs.sv
/*
 * CPU-visible result, channel-select and pin-split registers of the converter.
 * Assumes the sequencer on sys_clk supplies conv_done and sar_value, and that
 * the CPU holds bus_req until it sees bus_ack.
 */
// What this block does and what software must do
// RULE1: Result word is 16 bits with six low bits always zero.
// RULE2: Each conversion end copies the approximation value into the result word.
// RULE3: Upper eight result bits at FF09, lower two at FF08 bits 7:6.
// RULE4: Result word resets to zero and reads as one 16-bit access.
// RULE5: Byte result holds top eight bits, byte readable, resets to zero.
// RULE6: Software reads a finished result before writing mode, channel or pins.
// RULE7: Result reads and channel or pin writes take one extra wait cycle.
// RULE8: Software avoids these registers while the peripheral clock is stopped.
// RULE9: Channel field bits 2:0 at FF29 pick analog input zero to seven.
// RULE10: Software writes zeros to channel register bits 7 to 3.
// RULE11: Pin field n at FF2F makes the n lowest pins digital.
// RULE12: Software sets every converted pin as input in the port direction.
// RULE13: Software never selects a channel whose pin is set digital.
// RULE14: Software picks conversion time suited to the reference range.
// RULE15: Software stops conversion before changing conversion time fields.
// RULE16: Below 2.7 V software moves the low-voltage timing field off default.
// RULE17: Reset clears channel and pin registers: input zero, all pins analog.
// RULE18: Channel write aborts a conversion and restarts it while running.
// RULE19: CPU writes to result registers are ignored.
// RULE20: Pin split output follows the pin field on the cycle after writing.
`default_nettype none

module adc_result_channel_pin_regs #(
    parameter int PIN_COUNT = adc_pkg::PIN_CNT
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // CPU register access
    input  wire logic        bus_req,
    input  wire logic        bus_wr,
    input  wire logic        bus_word,
    input  wire logic [15:0] bus_addr,
    input  wire logic [15:0] bus_wdata,
    output var  logic [15:0] bus_rdata_ff,
    output var  logic        bus_wait_ff,
    output var  logic        bus_ack_ff,
    // Converter sequencer
    input  wire logic        conv_done,
    input  wire logic [9:0]  sar_value,
    input  wire logic        conv_run,
    output var  logic        conv_abort_ff,
    output var  logic        conv_restart_ff,
    // Channel and pin control
    output var  logic [2:0]  chan_sel_ff,
    output var  logic [7:0]  pin_digital_ff
);
    if (PIN_COUNT != adc_pkg::PIN_CNT) begin : g_bad_pins
        $error("PIN_COUNT must equal eight");
    end

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] split_pins(input logic [3:0] n);
        logic [7:0] d;
        d = 8'h00;
        for (int i = 0; i < adc_pkg::PIN_CNT; i++) begin
            d[i] = (4'(i) < n);
        end
        return d;
    endfunction : split_pins

    function automatic logic needs_wait(input logic wr, input logic [15:0] a);
        logic res_hit;
        res_hit = (a == adc_pkg::OFF_RESULT_LO) || (a == adc_pkg::OFF_RESULT_HI)
                || (a == adc_pkg::OFF_RESULT_BYTE);
        return wr ? (a == adc_pkg::OFF_CHAN_SEL || a == adc_pkg::OFF_PIN_CFG) : res_hit;
    endfunction : needs_wait

    // ----------------------------------------------------------------
    // Result store
    // ----------------------------------------------------------------
    adc_result_if res ();
    assign res.load = conv_done; // RULE2
    assign res.successive_approx_reg  = sar_value;

    adc_result_store i_adc_result_store (
        .sys_clk (sys_clk),
        .rst     (rst),
        .res     (res.store)
    );

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    adc_pkg::bus_state_t state_ff;
    logic                take;
    logic [3:0]          pin_cfg_ff;
    logic                wr_chan;
    logic                wr_pin;

    assign take    = (state_ff == adc_pkg::BUS_IDLE) && bus_req;
    assign wr_chan = take && bus_wr && (bus_addr == adc_pkg::OFF_CHAN_SEL);
    assign wr_pin  = take && bus_wr && (bus_addr == adc_pkg::OFF_PIN_CFG);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff    <= adc_pkg::BUS_IDLE;
            bus_wait_ff <= 1'b0;
            bus_ack_ff  <= 1'b0;
        end else begin
            unique case (state_ff)
                adc_pkg::BUS_IDLE: begin
                    bus_ack_ff <= 1'b0;
                    if (bus_req && needs_wait(bus_wr, bus_addr)) begin
                        state_ff    <= adc_pkg::BUS_WAIT; // RULE7
                        bus_wait_ff <= 1'b1;
                    end else if (bus_req) begin
                        state_ff   <= adc_pkg::BUS_DONE;
                        bus_ack_ff <= 1'b1;
                    end
                end
                adc_pkg::BUS_WAIT: begin
                    state_ff    <= adc_pkg::BUS_DONE;
                    bus_wait_ff <= 1'b0;
                    bus_ack_ff  <= 1'b1;
                end
                adc_pkg::BUS_DONE: begin
                    state_ff   <= adc_pkg::BUS_IDLE;
                    bus_ack_ff <= 1'b0;
                end
            endcase
        end
    end

    // Read data is captured at the take edge and stands until the next read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_rdata_ff <= adc_pkg::RDATA_RESET;
        end else if (take && !bus_wr) begin
            unique case (bus_addr)
                adc_pkg::OFF_RESULT_LO:
                    bus_rdata_ff <= bus_word ? res.word : {8'h00, res.word[7:0]}; // RULE3 RULE4
                adc_pkg::OFF_RESULT_HI:   bus_rdata_ff <= {8'h00, res.word[15:8]}; // RULE3
                adc_pkg::OFF_RESULT_BYTE: bus_rdata_ff <= {8'h00, res.byte_hi}; // RULE5
                adc_pkg::OFF_CHAN_SEL:    bus_rdata_ff <= {13'h0000, chan_sel_ff};
                adc_pkg::OFF_PIN_CFG:     bus_rdata_ff <= {12'h000, pin_cfg_ff};
                default:                  bus_rdata_ff <= adc_pkg::RDATA_RESET;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Channel select and pin split
    // ----------------------------------------------------------------
    // Upper bits are not stored, so they always read back as zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            chan_sel_ff <= adc_pkg::CHAN_RESET; // RULE17
        end else if (wr_chan) begin
            chan_sel_ff <= bus_wdata[adc_pkg::CHAN_BITS-1:0]; // RULE9
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_cfg_ff     <= adc_pkg::PIN_RESET; // RULE17
            pin_digital_ff <= split_pins(adc_pkg::PIN_RESET);
        end else if (wr_pin) begin
            pin_cfg_ff     <= bus_wdata[adc_pkg::PIN_BITS-1:0];
            // Prohibited codes above eight saturate to all digital
            pin_digital_ff <= split_pins(bus_wdata[adc_pkg::PIN_BITS-1:0]); // RULE11 RULE20
        end
    end

    // Abort pulse; the sequencer restarts only while running
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            conv_abort_ff   <= 1'b0;
            conv_restart_ff <= 1'b0;
        end else begin
            conv_abort_ff   <= wr_chan; // RULE18
            conv_restart_ff <= wr_chan && conv_run; // RULE18
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_wait_then_ack;
        bus_wait_ff && !bus_ack_ff ##1 !bus_wait_ff && bus_ack_ff ##1 !bus_ack_ff;
    endsequence
    sequence s_ack_now;
        !bus_wait_ff && bus_ack_ff ##1 !bus_ack_ff;
    endsequence

    a_wait_slow_access: assert property (take && needs_wait(bus_wr, bus_addr) |=> s_wait_then_ack) // RULE7
        else $error("missing wait cycle");
    a_nowait_fast_access: assert property (take && !needs_wait(bus_wr, bus_addr) |=> s_ack_now) // RULE7
        else $error("unexpected wait cycle");
    a_word_read_full: assert property (take && !bus_wr && bus_word
        && bus_addr == adc_pkg::OFF_RESULT_LO |=> bus_rdata_ff == $past(res.word)) // RULE4
        else $error("16-bit result read wrong");
    a_hi_byte_read: assert property (take && !bus_wr && bus_addr == adc_pkg::OFF_RESULT_HI
        |=> bus_rdata_ff[7:0] == $past(res.word[15:8])) // RULE3
        else $error("upper result byte read wrong");
    a_chan_write_take: assert property (wr_chan |=> chan_sel_ff == $past(bus_wdata[2:0])) // RULE9
        else $error("channel select not written");
    a_chan_abort_pulse: assert property (wr_chan |=> conv_abort_ff
        && conv_restart_ff == $past(conv_run) ##1 !conv_abort_ff) // RULE18
        else $error("channel write abort wrong");
    a_pin_split_decode: assert property (wr_pin |=> pin_digital_ff == split_pins(pin_cfg_ff)
        && pin_cfg_ff == $past(bus_wdata[3:0])) // RULE11
        else $error("pin split not applied");
    a_reset_clears_regs: assert property (disable iff (1'b0) rst |=> chan_sel_ff == 3'h0
        && pin_digital_ff == 8'h00) // RULE17
        else $error("channel or pin not cleared by reset");
endmodule : adc_result_channel_pin_regs

`default_nettype wire

// ### adc_cpu_model.sv
/*
 * CPU bus master model for the converter result, channel and pin registers.
 * Assumes sys_clk runs throughout and the block acks every taken access.
 */
`default_nettype none

module adc_cpu_model (
    // Clock
    input  wire logic        sys_clk,
    // Register access
    output var  logic        bus_req,
    output var  logic        bus_wr,
    output var  logic        bus_word,
    output var  logic [15:0] bus_addr,
    output var  logic [15:0] bus_wdata,
    input  wire logic [15:0] bus_rdata_ff,
    input  wire logic        bus_wait_ff,
    input  wire logic        bus_ack_ff
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        bus_req   = 1'b0;
        bus_wr    = 1'b0;
        bus_word  = 1'b0;
        bus_addr  = 16'h0000;
        bus_wdata = 16'h0000;
    end

    // Peripheral clock is never stopped while an access is pending
    task automatic xfer(input logic wr, input logic wd, input logic [15:0] a,
                        input logic [15:0] d, output logic [15:0] rd, output logic w);
        int n;
        n = 0;
        w = 1'b0;
        @(posedge sys_clk);
        #1;
        bus_req   = 1'b1;
        bus_wr    = wr;
        bus_word  = wd;
        bus_addr  = a;
        bus_wdata = d;
        do begin
            @(posedge sys_clk);
            #1;
            if (bus_wait_ff === 1'b1) w = 1'b1;
            n++;
        end while (bus_ack_ff !== 1'b1 && n < 20);
        // A missing ack poisons both results so every rd_chk and wr_chk caller sees a mismatch
        rd = (bus_ack_ff === 1'b1) ? bus_rdata_ff : 16'hxxxx;
        if (bus_ack_ff !== 1'b1) w = 1'bx;
        // Released lines must not keep looking valid
        bus_req   = 1'b0;
        bus_addr  = ~a;
        bus_wdata = ~d;
    endtask : xfer
endmodule : adc_cpu_model

`default_nettype wire

// ### tb_adc_result_channel_pin_regs.sv
/*
 * Self-checking bench for the converter result, channel and pin registers.
 * Assumes the CPU model in adc_cpu_model.sv and a 125 MHz sys_clk.
 */
`default_nettype none

module tb_adc_result_channel_pin_regs;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        bus_req, bus_wr, bus_word, bus_wait_ff, bus_ack_ff;
    logic [15:0] bus_addr, bus_wdata, bus_rdata_ff, rd;
    logic        conv_done = 1'b0;
    logic        conv_run = 1'b0;
    logic [9:0]  sar_value = 10'h000;
    logic [9:0]  s;
    logic        conv_abort_ff, conv_restart_ff, w, last_restart;
    logic [2:0]  chan_sel_ff;
    logic [7:0]  pin_digital_ff;
    int          miscompares = 0;
    int          check_count = 0;
    int          seed = 10;
    int          aborts = 0;
    int          a0;

    always #4 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (conv_abort_ff === 1'b1) begin
            aborts++;
            last_restart = conv_restart_ff;
        end
    end

    adc_result_channel_pin_regs i_adc_result_channel_pin_regs (
        .sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .bus_wr(bus_wr),
        .bus_word(bus_word), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata_ff(bus_rdata_ff), .bus_wait_ff(bus_wait_ff), .bus_ack_ff(bus_ack_ff),
        .conv_done(conv_done), .sar_value(sar_value), .conv_run(conv_run),
        .conv_abort_ff(conv_abort_ff), .conv_restart_ff(conv_restart_ff),
        .chan_sel_ff(chan_sel_ff), .pin_digital_ff(pin_digital_ff));

    adc_cpu_model i_adc_cpu_model (
        .sys_clk(sys_clk), .bus_req(bus_req), .bus_wr(bus_wr), .bus_word(bus_word),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata_ff(bus_rdata_ff),
        .bus_wait_ff(bus_wait_ff), .bus_ack_ff(bus_ack_ff));

    function automatic logic [15:0] exp_word(logic [9:0] v);
        return {v, 6'h00};
    endfunction : exp_word

    function automatic logic [15:0] exp_pins(int n);
        return (n >= 8) ? 16'h00ff : 16'((1 << n) - 1);
    endfunction : exp_pins

    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rd_chk(string nm, logic [15:0] a, logic wd, logic [15:0] e, logic ew);
        i_adc_cpu_model.xfer(1'b0, wd, a, 16'h0000, rd, w);
        chk(nm, e, rd);
        chk({nm, " wait"}, {15'h0000, ew}, {15'h0000, w});
    endtask : rd_chk

    task automatic wr_chk(string nm, logic [15:0] a, logic [15:0] d);
        i_adc_cpu_model.xfer(1'b1, 1'b0, a, d, rd, w);
        chk({nm, " wait"}, 16'h0001, {15'h0000, w});
    endtask : wr_chk

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    initial begin
        #100000;
        miscompares++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        rd_chk("word", 16'hff08, 1'b1, 16'h0000, 1'b1);
        rd_chk("byte", 16'hff1f, 1'b0, 16'h0000, 1'b1);
        rd_chk("chan", 16'hff29, 1'b0, 16'h0000, 1'b0);
        rd_chk("pins", 16'hff2f, 1'b0, 16'h0000, 1'b0);
        chk("pin out", 16'h0000, {8'h00, pin_digital_ff});
        $display("reset test done");
        // Full-scale and one-count results first, then random
        for (int i = 0; i < 8; i++) begin
            s = (i == 0) ? 10'h3ff : (i == 1) ? 10'h001 : 10'($random(seed));
            @(posedge sys_clk);
            #1;
            conv_done = 1'b1;
            sar_value = s;
            conv_run  = 1'($random(seed));
            @(posedge sys_clk);
            #1;
            conv_done = 1'b0;
            sar_value = ~s;
            rd_chk("word", 16'hff08, 1'b1, exp_word(s), 1'b1);
            rd_chk("lo byte", 16'hff08, 1'b0, {8'h00, s[1:0], 6'h00}, 1'b1);
            rd_chk("hi byte", 16'hff09, 1'b0, {8'h00, s[9:2]}, 1'b1);
            i_adc_cpu_model.xfer(1'b1, 1'b1, 16'hff08, 16'h5a5a, rd, w);
            rd_chk("byte", 16'hff1f, 1'b0, {8'h00, s[9:2]}, 1'b1);
            rd_chk("word", 16'hff08, 1'b1, exp_word(s), 1'b1);
        end
        $display("result test done");
        // Result already read above, so channel writes are safe
        for (int n = 0; n < 8; n++) begin
            a0 = aborts;
            conv_run = n[0];
            wr_chk("chan", 16'hff29, 16'(n));
            chk("chan out", 16'(n), {13'h0000, chan_sel_ff});
            chk("aborts", 16'(a0 + 1), 16'(aborts));
            chk("restart", {15'h0000, conv_run}, {15'h0000, last_restart});
            rd_chk("chan", 16'hff29, 1'b0, 16'(n), 1'b0);
        end
        $display("channel test done");
        for (int n = 8; n >= 0; n--) begin
            wr_chk("pins", 16'hff2f, 16'(n));
            chk("pin out", exp_pins(n), {8'h00, pin_digital_ff});
            rd_chk("pins", 16'hff2f, 1'b0, 16'(n), 1'b0);
        end
        rd_chk("unmapped", 16'hff30, 1'b0, 16'h0000, 1'b0);
        $display("pin test done");
        // Second reset over non-zero state must clear everything again
        wr_chk("pins", 16'hff2f, 16'h0005);
        @(posedge sys_clk);
        #1;
        rst = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        chk("pin out", 16'h0000, {8'h00, pin_digital_ff});
        rd_chk("word", 16'hff08, 1'b1, 16'h0000, 1'b1);
        rd_chk("byte", 16'hff1f, 1'b0, 16'h0000, 1'b1);
        rd_chk("chan", 16'hff29, 1'b0, 16'h0000, 1'b0);
        $display("second reset test done");
        final_report();
    end
endmodule : tb_adc_result_channel_pin_regs

`default_nettype wire
